// ===== rtl/wpdr_pkg.sv
package wpdr_pkg;

  // ------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] WPDR_OFS_POL_CTRL  = 4'h0;
  localparam logic [3:0] WPDR_OFS_RISE_DB   = 4'h4;

  // ------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------
  localparam int         WPDR_POL_W         = 4;
  localparam int         WPDR_IN_BIT        = 5;
  localparam int         WPDR_DB_W          = 6;
  localparam logic [3:0] WPDR_POL_RST       = 4'h0;
  localparam logic [5:0] WPDR_DB_PWRUP      = 6'h00;
  localparam logic [31:0] WPDR_UNMAPPED_RD  = 32'h0000_0000;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } wpdr_req_t;

  typedef struct packed {
    logic [3:0] wave;
    logic [3:0] ovr_level;
    logic       ovr_active;
  } wpdr_wave_t;

endpackage

// ===== rtl/wpdr_db_store.sv
`timescale 1ns/1ps
module wpdr_db_store
  import wpdr_pkg::*;
(
  // Clock
  input  wire logic                 mclk_i,
  // Power-on reset only
  input  wire logic                 por_i,
  // Write port
  input  wire logic                 we_i,
  input  wire logic [WPDR_DB_W-1:0] wdata_i,
  // Stored value
  output logic      [WPDR_DB_W-1:0] q_o
);

  // ------------------------------------------------------------
  // Dead-band value storage, untouched by system reset
  // ------------------------------------------------------------
  logic [WPDR_DB_W-1:0] val_r;

  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      val_r <= WPDR_DB_PWRUP;
    end else if (we_i) begin
      val_r <= wdata_i;
    end
  end

  assign q_o = val_r;

endmodule // wpdr_db_store

// ===== rtl/wpdr_regs.sv
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Polarity bit inverts its waveform output
// - Unimplemented control and dead-band bits read zero
// - Six-bit rising dead-band count, sets rise delay
// - Dead-band kept across non power-on resets
// - Override levels bypass polarity inversion
module wpdr_regs
  import wpdr_pkg::*;
(
  // Clock and resets
  input  wire logic                  mclk_i,
  input  wire logic                  srst_i,
  input  wire logic                  por_i,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [3:0]            avs_byteenable_i,
  input  wire logic [31:0]           avs_writedata_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Waveform path
  input  wire logic                  wave_in_i,
  input  wire logic [3:0]            wave_raw_i,
  input  wire logic                  ovr_active_i,
  input  wire logic [3:0]            ovr_level_i,
  output logic      [3:0]            waveform_out_o,
  output logic      [WPDR_DB_W-1:0]  rise_delay_value_o
);

  // ------------------------------------------------------------
  // Local types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WPDR_BUS_IDLE = 2'b01,
    WPDR_BUS_ACK  = 2'b10
  } wpdr_bus_state_t;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic wpdr_sel(
    input logic [3:0] addr,
    input logic [3:0] ofs
  );
    return (addr == ofs);
  endfunction

  function automatic logic [31:0] wpdr_pad(
    input logic [7:0] low_byte
  );
    return {24'h00_0000, low_byte};
  endfunction

  // ------------------------------------------------------------
  // Synchroniser signals
  // ------------------------------------------------------------
  logic [2:0]            in_sync_r;
  logic                  in_level_r;
  logic                  in_level_nxt;

  // ------------------------------------------------------------
  // Bus signals
  // ------------------------------------------------------------
  wpdr_req_t             req;
  wpdr_bus_state_t       bus_state_r;
  wpdr_bus_state_t       bus_state_nxt;
  logic                  wait_nxt;
  wire                   req_any;
  wire                   bus_idle;
  wire                   access;
  wire                   sel_pol;
  wire                   sel_db;
  wire                   wr_lane0;
  wire                   rd_take;

  // ------------------------------------------------------------
  // Register signals
  // ------------------------------------------------------------
  logic [WPDR_POL_W-1:0] pol_r;
  logic [WPDR_POL_W-1:0] pol_nxt;
  wire                   pol_we;
  logic [WPDR_DB_W-1:0]  db_q;
  wire                   db_we;

  // ------------------------------------------------------------
  // Read path signals
  // ------------------------------------------------------------
  wire [7:0]             pol_byte;
  wire [7:0]             db_byte;
  wire [31:0]            rd_pol;
  wire [31:0]            rd_db;
  wire [31:0]            rd_mux;
  logic [31:0]           rd_nxt;

  // ------------------------------------------------------------
  // Output path signals
  // ------------------------------------------------------------
  wpdr_wave_t            wv;
  wire [3:0]             out_nxt;

  // ------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------
  assign in_level_nxt = (in_sync_r[1] == in_sync_r[2]) ? in_sync_r[2] : in_level_r;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      in_sync_r <= 3'h0;
    end else begin
      in_sync_r <= {in_sync_r[1:0], wave_in_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      in_level_r <= 1'b0;
    end else begin
      in_level_r <= in_level_nxt;
    end
  end

  // ------------------------------------------------------------
  // Bus request decode
  // ------------------------------------------------------------
  assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                 byteenable: avs_byteenable_i, writedata: avs_writedata_i};

  assign req_any  = req.read | req.write;
  assign bus_idle = (bus_state_r == WPDR_BUS_IDLE);
  assign access   = req_any & bus_idle;
  assign sel_pol  = wpdr_sel(req.address, WPDR_OFS_POL_CTRL);
  assign sel_db   = wpdr_sel(req.address, WPDR_OFS_RISE_DB);
  assign wr_lane0 = access & req.write & req.byteenable[0];
  assign rd_take  = access & req.read;

  // ------------------------------------------------------------
  // Bus handshake state machine
  // ------------------------------------------------------------
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      WPDR_BUS_IDLE: begin
        if (req_any) begin
          bus_state_nxt = WPDR_BUS_ACK;
        end
      end
      WPDR_BUS_ACK: begin
        bus_state_nxt = WPDR_BUS_IDLE;
      end
      default: begin
        bus_state_nxt = WPDR_BUS_IDLE;
      end
    endcase
  end

  assign wait_nxt = (bus_state_nxt != WPDR_BUS_ACK);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bus_state_r <= WPDR_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // Waitrequest is high while idle and low for the one answer cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= wait_nxt;
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  assign pol_we  = wr_lane0 & sel_pol;
  assign pol_nxt = pol_we ? req.writedata[WPDR_POL_W-1:0] : pol_r;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pol_r <= WPDR_POL_RST;
    end else begin
      pol_r <= pol_nxt;
    end
  end

  // ------------------------------------------------------------
  // Rising dead-band register
  // ------------------------------------------------------------
  assign db_we = wr_lane0 & sel_db;

  wpdr_db_store u_db (
    .mclk_i  (mclk_i),
    .por_i   (por_i),
    .we_i    (db_we),
    .wdata_i (req.writedata[WPDR_DB_W-1:0]),
    .q_o     (db_q)
  );

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  assign pol_byte = {2'b00, in_level_r, 1'b0, pol_r};
  assign db_byte  = {2'b00, db_q};
  assign rd_pol   = wpdr_pad(pol_byte);
  assign rd_db    = wpdr_pad(db_byte);
  assign rd_mux   = sel_pol ? rd_pol : sel_db ? rd_db : WPDR_UNMAPPED_RD;
  assign rd_nxt   = rd_take ? rd_mux : avs_readdata_o;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Output steering
  // ------------------------------------------------------------
  assign wv = '{wave: wave_raw_i, ovr_level: ovr_level_i, ovr_active: ovr_active_i};

  // Override levels skip the polarity stage
  for (genvar g = 0; g < WPDR_POL_W; g++) begin : g_steer
    assign out_nxt[g] = wv.ovr_active ? wv.ovr_level[g] : (wv.wave[g] ^ pol_r[g]);
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      waveform_out_o <= 4'h0;
    end else begin
      waveform_out_o <= out_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rise_delay_value_o <= 6'h00;
    end else begin
      rise_delay_value_o <= db_q;
    end
  end

endmodule // wpdr_regs

// ===== sim/wpdr_regs_properties.sv
`timescale 1ns/1ps
module wpdr_regs_properties
  import wpdr_pkg::*;
(
  // Bus and resets
  input wire logic mclk_i, srst_i, por_i, avs_read_i, avs_write_i, avs_waitrequest_o,
  input wire logic [3:0] avs_address_i, avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i, avs_readdata_o,
  // Waveform path
  input wire logic ovr_active_i,
  input wire logic [3:0] wave_raw_i, ovr_level_i, waveform_out_o,
  input wire logic [5:0] rise_delay_value_o
);
  logic [3:0] pol_r;
  logic [5:0] db_r;
  wire wr_w = avs_write_i & avs_waitrequest_o & avs_byteenable_i[0];
  wire db_w = wr_w & (avs_address_i == WPDR_OFS_RISE_DB);
  always_ff @(posedge mclk_i) begin
    if (srst_i) pol_r <= '0;
    else if (wr_w && avs_address_i == WPDR_OFS_POL_CTRL) pol_r <= avs_writedata_i[3:0];
    if (por_i) db_r <= '0;
    else if (db_w) db_r <= avs_writedata_i[5:0];
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  pol_out_a: assert property (!srst_i && !ovr_active_i |=>
    waveform_out_o == ($past(wave_raw_i) ^ $past(pol_r))) else $error("pol");
  ovr_lvl_a: assert property (!srst_i && ovr_active_i |=>
    waveform_out_o == $past(ovr_level_i)) else $error("ovr");
  rsv_zero_a: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:6] == '0 && !(avs_readdata_o[4] && avs_address_i == WPDR_OFS_POL_CTRL))
    else $error("rsv");
  db_out_a: assert property (db_w |-> ##2 rise_delay_value_o == db_r) else $error("db");
  ack_next_a: assert property (!srst_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("ack");
  ack_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait");
  cover property (avs_read_i && !avs_waitrequest_o);
  cover property (db_w);
  cover property (ovr_active_i);
endmodule // wpdr_regs_properties
bind wpdr_regs wpdr_regs_properties wpdr_regs_properties_i (.*);

// ===== sim/tb_wpdr_regs.sv
`timescale 1ns/1ps
module tb_wpdr_regs;
  import wpdr_pkg::*;
  logic mclk_i = 0, srst_i = 1, por_i = 1, avs_read_i = 0, avs_write_i = 0, wave_in_i = 0;
  logic ovr_active_i = 0, avs_waitrequest_o;
  logic [3:0] avs_address_i = '0, wave_raw_i = '0, ovr_level_i = '0, waveform_out_o;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, got;
  logic [5:0] rise_delay_value_o;
  int mismatches = 0, checks_done = 0;
  initial forever #20 mclk_i = ~mclk_i;
  wpdr_regs wpdr_regs_i (.*, .avs_byteenable_i(4'h1));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    got = avs_readdata_o;
    avs_read_i <= 0;
    avs_write_i <= 0;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20_000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    srst_i <= 0;
    por_i <= 0;
    bus(0, WPDR_OFS_POL_CTRL, '0); chk(got, '0);
    bus(1, WPDR_OFS_POL_CTRL, 32'hFFFF_FFFF);
    bus(0, WPDR_OFS_POL_CTRL, '0); chk(got, 32'h0000_000F);
    wave_raw_i <= 4'h5;
    repeat (2) @(posedge mclk_i); chk(waveform_out_o, 4'hA);
    ovr_active_i <= 1;
    ovr_level_i <= 4'h3;
    repeat (2) @(posedge mclk_i); chk(waveform_out_o, 4'h3);
    wave_in_i <= 1;
    bus(1, WPDR_OFS_RISE_DB, 32'h0000_00FF);
    bus(0, WPDR_OFS_POL_CTRL, '0); chk(got, 32'h0000_002F);
    bus(0, WPDR_OFS_RISE_DB, '0); chk(got, 32'h0000_003F);
    chk(rise_delay_value_o, 6'h3F);
    srst_i <= 1;
    @(posedge mclk_i) srst_i <= 0;
    bus(0, WPDR_OFS_RISE_DB, '0); chk(got, 32'h0000_003F);
    bus(0, 4'h8, '0); chk(got, '0);
    srst_i <= 1;
    por_i <= 1;
    @(posedge mclk_i) srst_i <= 0;
    por_i <= 0;
    bus(0, WPDR_OFS_RISE_DB, '0); chk(got, '0);
    close_out();
  end
endmodule // tb_wpdr_regs
